// ===== common/acc_defs.vh
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH
// register indices on the plain register port
`define ACC_REG_MODE      4'h0
`define ACC_REG_CAP_LOW   4'h1
`define ACC_REG_CAP_HIGH  4'h2
`define ACC_REG_TMR_LOW   4'h3
`define ACC_REG_TMR_HIGH  4'h4
`define ACC_REG_CTRL      4'h5
`define ACC_REG_IRQ_STAT  4'h6
`define ACC_REG_IRQ_MASK  4'h7
// mode register fields
`define ACC_MODE_CMP_EN   6
`define ACC_MODE_RISE     5
`define ACC_MODE_FALL     4
`define ACC_MODE_MATCH    3
`define ACC_MODE_TOGGLE   2
`define ACC_MODE_PWM      1
`define ACC_MODE_FIE      0
`define ACC_MODE_RESET    8'h00
`define ACC_MODE_WMASK    8'h7f
// counter control fields
`define ACC_CTRL_RUN      0
`define ACC_CTRL_WDT      1
`define ACC_CTRL_EVFLAG   2
`define ACC_CTRL_RESET    8'h00
// status / mask fields
`define ACC_IRQ_CAPTURE   0
`define ACC_IRQ_MATCH     1
`define ACC_IRQ_WDT       2
`define ACC_IRQ_RESET     8'h00
`define ACC_TMR_RESET     16'h0000
`define ACC_CAP_RESET     8'h00
`define ACC_WDT_CNT_RESET 8'h00
`define ACC_WDT_RST_CYCLES 8'h04
`endif

// ===== dv/acc_module_props.sv
`timescale 1ns/1ps
module acc_module_props #(parameter WATCHDOG_CAPABLE = 1) (
  // clock and register port
  input wire       clk,
  input wire       arst_n,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata_q,
  // pin and events
  input wire       module_io_pin_out_q,
  input wire       module_io_pin_oe_q,
  input wire       irq_q,
  input wire       module_irq_q,
  input wire       internal_reset_q
);
  // shadows follow software writes; a watchdog reset is not seen, so no pwm is in use then
  reg [7:0] mode_q, mask_q;
  reg [2:0] quiet_q;
  reg       wdt_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= 8'h00;
      mask_q <= 8'h00;
      quiet_q <= 3'h0;
      wdt_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 4'h0) mode_q <= reg_wdata & 8'h7f;
      if (reg_wr && reg_addr == 4'h5) wdt_q <= reg_wdata[1];
      if (reg_wr && reg_addr == 4'h7) mask_q <= reg_wdata;
      quiet_q <= {quiet_q[1:0], !(mode_q[1] | mode_q[2])};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_wdt_hold;
    internal_reset_q [*4] ##1 !internal_reset_q;
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00) else $error("read data not idle");
  a_mode_bit7: assert property ($past(reg_rd) && $past(reg_addr) == 4'h0 |-> !reg_rdata_q[7])
    else $error("reserved mode bit read high");
  a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > 4'h7 |-> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_pwm_drive: assert property (mode_q[1] && mode_q[6] && $past(mode_q[1] && mode_q[6]) |-> module_io_pin_oe_q)
    else $error("pwm pin not driven");
  a_pin_quiet: assert property (quiet_q == 3'h7 |-> $stable(module_io_pin_out_q))
    else $error("pin moved outside drive modes");
  a_irq_masked: assert property (mask_q == 8'h00 && $past(mask_q) == 8'h00 && $past(mask_q, 2) == 8'h00 |-> !irq_q)
    else $error("irq with all masked");
  a_mirq_fie: assert property (!mode_q[0] && !$past(mode_q[0]) && !$past(mode_q[0], 2) |-> !module_irq_q)
    else $error("module irq without enable");
  a_wdt_pulse: assert property ($rose(internal_reset_q) |-> s_wdt_hold) else $error("reset pulse length");
  a_wdt_only4: assert property ($rose(internal_reset_q) |-> WATCHDOG_CAPABLE != 0 && wdt_q)
    else $error("reset without watchdog enabled");
endmodule // acc_module_props

// ===== dv/acc_module_tb.sv
`timescale 1ns/1ps
`include "acc_defs.vh"
module acc_module_tb;
  reg        clk, arst_n, reg_wr, reg_rd, lvl, rd_pend, hit, o;
  reg  [3:0] reg_addr;
  reg  [7:0] reg_wdata, m, d;
  reg [15:0] t, cap;
  wire [7:0] rdata;
  wire       pout, poe, irq, mirq, irst, ext_pin, pin_w;
  reg  [7:0] exp_q[$];
  string     nm_q[$];
  integer    fails, checked, i, k, n;
  assign pin_w = poe ? pout : ext_pin;
  acc_pin_model pin_u (.lvl_req(lvl), .pin(ext_pin));
  acc_module dut_u (.clk(clk), .arst_n(arst_n), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata), .module_io_pin_in(pin_w), .module_io_pin_out_q(pout),
    .module_io_pin_oe_q(poe), .irq_q(irq), .module_irq_q(mirq), .internal_reset_q(irst));
  // ==========
  // bus and compare
  task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [3:0] a, input [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [3:0] a, input [7:0] v, input string nm);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(v);
    nm_q.push_back(nm);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  always @(posedge clk) begin
    if (rd_pend) check(nm_q.pop_front(), rdata, exp_q.pop_front());
    rd_pend <= reg_rd;
  end
  task stop_test;
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #40000;
    fails = fails + 1;
    stop_test;
  end
  // ==========
  // scenarios
  initial begin
    {reg_wr, reg_rd, rd_pend, lvl} = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    arst_n = 1'b0;
    fails = 0;
    checked = 0;
    cap = 16'h0000;
    i = $urandom(32'h6f45);
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    for (i = 0; i < 10; i = i + 1) rd(i[3:0], 8'h00, "reset value");
    wr(`ACC_REG_MODE, 8'h7f);
    rd(`ACC_REG_MODE, 8'h7f, "mode");
    wr(`ACC_REG_IRQ_MASK, 8'h07);
    for (i = 0; i < 6; i = i + 1) begin
      m = (i < 2) ? 8'h21 : (i < 4) ? 8'h11 : 8'h31;
      t = 16'($urandom);
      wr(`ACC_REG_MODE, m);
      wr(`ACC_REG_TMR_LOW, t[7:0]);
      wr(`ACC_REG_TMR_HIGH, t[15:8]);
      hit = lvl ? m[4] : m[5];
      if (hit) cap = t;
      lvl <= ~lvl;
      repeat (8) @(posedge clk);
      check("module irq", {7'h0, mirq}, {7'h0, hit});
      check("irq", {7'h0, irq}, {7'h0, hit});
      rd(`ACC_REG_CAP_LOW, cap[7:0], "cap low");
      rd(`ACC_REG_CAP_HIGH, cap[15:8], "cap high");
      rd(`ACC_REG_CTRL, {5'h0, hit, 2'h0}, "ctrl flag");
      rd(`ACC_REG_IRQ_STAT, {7'h0, hit}, "status");
      wr(`ACC_REG_CTRL, 8'h00);
      wr(`ACC_REG_IRQ_STAT, 8'h07);
    end
    wr(`ACC_REG_CAP_LOW, 8'h20);
    wr(`ACC_REG_CAP_HIGH, 8'h00);
    wr(`ACC_REG_TMR_LOW, 8'h00);
    wr(`ACC_REG_TMR_HIGH, 8'h00);
    wr(`ACC_REG_MODE, 8'h48);
    wr(`ACC_REG_CTRL, 8'h03);
    n = 0;
    for (i = 0; i < 80; i = i + 1) begin
      @(posedge clk);
      n = n + irst;
    end
    check("reset pulse", n[7:0], `ACC_WDT_RST_CYCLES);
    wr(`ACC_REG_CTRL, 8'h00);
    d = 8'($urandom_range(255, 1));
    wr(`ACC_REG_CAP_LOW, 8'h40);
    wr(`ACC_REG_CAP_HIGH, 8'h40);
    wr(`ACC_REG_MODE, 8'h42);
    wr(`ACC_REG_CTRL, 8'h01);
    for (k = 0; k < 2; k = k + 1) begin
      repeat (300) @(posedge clk);
      n = 0;
      for (i = 0; i < 256; i = i + 1) begin
        @(posedge clk);
        n = n + pout;
      end
      check("pwm high", n[7:0], (k != 0) ? 8'h00 - d : 8'hc0);
      wr(`ACC_REG_CAP_HIGH, d);
    end
    rd(`ACC_REG_CAP_LOW, d, "pwm reload");
    check("pwm drive", {7'h0, poe}, 8'h01);
    wr(`ACC_REG_CTRL, 8'h00);
    wr(`ACC_REG_CAP_LOW, 8'h30);
    wr(`ACC_REG_CAP_HIGH, 8'h12);
    wr(`ACC_REG_TMR_LOW, 8'h10);
    wr(`ACC_REG_TMR_HIGH, 8'h12);
    wr(`ACC_REG_MODE, 8'h4c);
    wr(`ACC_REG_IRQ_STAT, 8'h07);
    o = pout;
    wr(`ACC_REG_CTRL, 8'h01);
    repeat (60) @(posedge clk);
    check("toggle", {7'h0, pout}, {7'h0, ~o});
    rd(`ACC_REG_CTRL, 8'h05, "match flag");
    rd(`ACC_REG_IRQ_STAT, 8'h02, "match status");
    repeat (3) @(posedge clk);
    stop_test;
  end
endmodule // acc_module_tb
bind acc_module acc_module_props #(.WATCHDOG_CAPABLE(WATCHDOG_CAPABLE)) props_u (.clk, .arst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .module_io_pin_out_q, .module_io_pin_oe_q, .irq_q, .module_irq_q,
  .internal_reset_q);

// ===== dv/acc_pin_model.sv
`timescale 1ns/1ps
module acc_pin_model (
  // requested level and pin
  input  wire lvl_req,
  output reg  pin
);
  // the far side is unrelated to clk, so each edge lands at an odd point of the cycle
  initial pin = 1'b0;
  always @(lvl_req) pin <= #(1.3 * (1 + $urandom % 5)) lvl_req;
endmodule // acc_pin_model

// ===== src/acc_edge_detect.v
`timescale 1ns/1ps
`include "acc_defs.vh"
module acc_edge_detect (
  // clock and reset
  input  wire clk,
  input  wire arst_n,
  input  wire ce,
  // pin and edge selection
  input  wire pin_in,
  input  wire rise_en,
  input  wire fall_en,
  // result
  output reg  edge_hit,
  output wire pin_level
);
  reg sync1_q;
  reg sync2_q;
  reg prev_q;

  assign pin_level = sync2_q;

  // two stages before anything looks at the pin, then one for history
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else if (ce) begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  always @* begin
    edge_hit = (rise_en & sync2_q & ~prev_q) | (fall_en & ~sync2_q & prev_q);
  end
endmodule // acc_edge_detect

// ===== src/acc_module.v
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "acc_defs.vh"
// How it works
// - with capture enabled, a valid pin edge copies the timer into the register pair
// - rise bit captures rising edges, fall bit falling, both capture either edge
// - module interrupt request only while event flag and flag-interrupt enable both set
// - compare and match enabled: timer equal to register pair sets event flag
// - toggle, match and compare enabled: each match inverts the output pin
// - pwm: pin low while timer low byte below low compare byte, else high
// - pwm: low byte wrapping ff to 00 reloads low compare byte from high byte
// - pwm mode entered with pulse-width and compare-enable bits set
// - one shared timer is the time base, so pwm frequency is common
// - mode register bit 7 reserved, bits 6..0 fields, reset to zero
// - watchdog: enabled and in compare mode, a match makes internal reset only
module acc_module #(
  parameter WATCHDOG_CAPABLE = 1
) (
  // clock and reset
  input  wire       clk,
  input  wire       arst_n,
  input  wire       ce,
  // register port
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata_q,
  // module pin
  input  wire       module_io_pin_in,
  output reg        module_io_pin_out_q,
  output reg        module_io_pin_oe_q,
  // events
  output reg        irq_q,
  output reg        module_irq_q,
  output reg        internal_reset_q
);
  // ==========================================================
  // registers
  reg  [7:0]  module_mode_control_q;
  reg  [7:0]  module_low_byte_q;
  reg  [7:0]  module_high_byte_q;
  reg  [15:0] timer_q;
  reg  [7:0]  array_counter_control_q;
  reg  [7:0]  irq_stat_q;
  reg  [7:0]  irq_mask_q;
  reg  [7:0]  wdt_cnt_q;
  reg         match_arm_q;

  // one write select per register index; unmapped indices select nothing
  reg         wr_mode;
  reg         wr_low;
  reg         wr_high;
  reg         wr_tlow;
  reg         wr_thigh;
  reg         wr_ctrl;
  reg         wr_stat;
  reg         wr_mask;

  always @* begin
    wr_mode  = 1'b0;
    wr_low   = 1'b0;
    wr_high  = 1'b0;
    wr_tlow  = 1'b0;
    wr_thigh = 1'b0;
    wr_ctrl  = 1'b0;
    wr_stat  = 1'b0;
    wr_mask  = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        `ACC_REG_MODE:     wr_mode  = 1'b1;
        `ACC_REG_CAP_LOW:  wr_low   = 1'b1;
        `ACC_REG_CAP_HIGH: wr_high  = 1'b1;
        `ACC_REG_TMR_LOW:  wr_tlow  = 1'b1;
        `ACC_REG_TMR_HIGH: wr_thigh = 1'b1;
        `ACC_REG_CTRL:     wr_ctrl  = 1'b1;
        `ACC_REG_IRQ_STAT: wr_stat  = 1'b1;
        `ACC_REG_IRQ_MASK: wr_mask  = 1'b1;
        default:           wr_mode  = 1'b0;
      endcase
    end
  end

  wire compare_enable        = module_mode_control_q[`ACC_MODE_CMP_EN];
  wire rise_capture_enable   = module_mode_control_q[`ACC_MODE_RISE];
  wire fall_capture_enable   = module_mode_control_q[`ACC_MODE_FALL];
  wire match_flag_enable     = module_mode_control_q[`ACC_MODE_MATCH];
  wire toggle_enable         = module_mode_control_q[`ACC_MODE_TOGGLE];
  wire pulse_width_enable    = module_mode_control_q[`ACC_MODE_PWM];
  wire flag_interrupt_enable = module_mode_control_q[`ACC_MODE_FIE];
  wire counter_run           = array_counter_control_q[`ACC_CTRL_RUN];
  wire watchdog_enable_bit   = array_counter_control_q[`ACC_CTRL_WDT];
  wire module_event_flag     = array_counter_control_q[`ACC_CTRL_EVFLAG];

  // ==========================================================
  // edge detection on the pin
  wire edge_hit;

  acc_edge_detect u_edge (
    .clk       (clk),
    .arst_n    (arst_n),
    .ce        (ce),
    .pin_in    (module_io_pin_in),
    .rise_en   (rise_capture_enable),
    .fall_en   (fall_capture_enable),
    .edge_hit  (edge_hit),
    .pin_level ()
  );

  // ==========================================================
  // mode decode
  wire pwm_mode   = pulse_width_enable && compare_enable;
  wire capture_ev = edge_hit && !pwm_mode;
  wire timer_eq   = (timer_q == {module_high_byte_q, module_low_byte_q});
  // the timer holds a value for many clocks when slow, so only the first
  // clock of equality counts as a match
  wire match_raw  = compare_enable && !pwm_mode && timer_eq;
  wire match_ev   = match_raw && match_arm_q;
  wire flag_ev    = capture_ev || (match_ev && match_flag_enable);
  // the watchdog needs a compare mode, so the match bit is part of it
  wire wdt_ev     = (WATCHDOG_CAPABLE != 0) && watchdog_enable_bit && match_ev && match_flag_enable;
  wire low_wrap   = counter_run && (timer_q[7:0] == 8'hff);
  wire toggle_ev  = match_ev && toggle_enable && match_flag_enable;
  wire drive_mode = pwm_mode || (compare_enable && toggle_enable && match_flag_enable);

  // next-state values
  reg  [15:0] timer_d;
  reg  [7:0]  module_low_byte_d;
  reg  [7:0]  module_high_byte_d;
  reg  [7:0]  array_counter_control_d;
  reg         pin_out_d;
  reg  [7:0]  wdt_cnt_d;
  reg         internal_reset_d;
  reg  [7:0]  reg_rdata_d;

  // ==========================================================
  // shared timer, one per array; this module holds the array's copy
  always @* begin
    timer_d = timer_q;
    if (wr_tlow) begin
      timer_d[7:0] = reg_wdata;
    end else if (wr_thigh) begin
      timer_d[15:8] = reg_wdata;
    end else if (counter_run) begin
      timer_d = timer_q + 16'h0001;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_q <= `ACC_TMR_RESET;
    end else if (ce) begin
      timer_q <= timer_d;
    end
  end

  // ==========================================================
  // compare/capture pair; a capture beats a software write in the same cycle
  always @* begin
    module_low_byte_d  = module_low_byte_q;
    module_high_byte_d = module_high_byte_q;
    if (capture_ev) begin
      module_low_byte_d  = timer_q[7:0];
      module_high_byte_d = timer_q[15:8];
    end else begin
      if (wr_low) begin
        module_low_byte_d = reg_wdata;
      end else if (pwm_mode && low_wrap) begin
        module_low_byte_d = module_high_byte_q;
      end
      if (wr_high) begin
        module_high_byte_d = reg_wdata;
      end
    end
  end

  // software writes run, watchdog and flag bits; a hardware set of the flag wins
  always @* begin
    array_counter_control_d = array_counter_control_q;
    if (wr_ctrl) begin
      array_counter_control_d[`ACC_CTRL_RUN]    = reg_wdata[`ACC_CTRL_RUN];
      array_counter_control_d[`ACC_CTRL_WDT]    = reg_wdata[`ACC_CTRL_WDT];
      array_counter_control_d[`ACC_CTRL_EVFLAG] = reg_wdata[`ACC_CTRL_EVFLAG];
    end
    if (flag_ev) begin
      array_counter_control_d[`ACC_CTRL_EVFLAG] = 1'b1;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      module_mode_control_q   <= `ACC_MODE_RESET;
      module_low_byte_q       <= `ACC_CAP_RESET;
      module_high_byte_q      <= `ACC_CAP_RESET;
      array_counter_control_q <= `ACC_CTRL_RESET;
      match_arm_q             <= 1'b1;
    end else if (ce) begin
      match_arm_q             <= !match_raw;
      module_low_byte_q       <= module_low_byte_d;
      module_high_byte_q      <= module_high_byte_d;
      array_counter_control_q <= array_counter_control_d;
      if (wr_mode) begin
        module_mode_control_q <= reg_wdata & `ACC_MODE_WMASK;
      end
    end
  end

  // ==========================================================
  // pin drive; outside the drive modes the last level is held
  always @* begin
    pin_out_d = module_io_pin_out_q;
    if (pwm_mode) begin
      pin_out_d = (timer_q[7:0] >= module_low_byte_q);
    end else if (toggle_ev) begin
      pin_out_d = ~module_io_pin_out_q;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      module_io_pin_out_q <= 1'b0;
      module_io_pin_oe_q  <= 1'b0;
    end else if (ce) begin
      module_io_pin_out_q <= pin_out_d;
      module_io_pin_oe_q  <= drive_mode;
    end
  end

  // ==========================================================
  // interrupt status, mask and watchdog reset pulse
  wire [7:0] stat_set = {5'h00, wdt_ev, match_ev, capture_ev};
  localparam [7:0] STAT_RESET = `ACC_IRQ_RESET;

  // one sticky bit per event; set wins over a write-one clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_stat
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          irq_stat_q[gi] <= STAT_RESET[gi];
        end else if (ce) begin
          if (stat_set[gi]) begin
            irq_stat_q[gi] <= 1'b1;
          end else if (wr_stat && reg_wdata[gi]) begin
            irq_stat_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // internal reset only; the external reset pin is never driven
  always @* begin
    wdt_cnt_d = wdt_cnt_q;
    if (wdt_ev) begin
      wdt_cnt_d = `ACC_WDT_RST_CYCLES;
    end else if (wdt_cnt_q != 8'h00) begin
      wdt_cnt_d = wdt_cnt_q - 8'h01;
    end
    internal_reset_d = wdt_ev || (wdt_cnt_q > 8'h01);
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask_q       <= `ACC_IRQ_RESET;
      irq_q            <= 1'b0;
      module_irq_q     <= 1'b0;
      wdt_cnt_q        <= `ACC_WDT_CNT_RESET;
      internal_reset_q <= 1'b0;
    end else if (ce) begin
      if (wr_mask) begin
        irq_mask_q <= reg_wdata;
      end
      irq_q            <= |(irq_stat_q & irq_mask_q);
      module_irq_q     <= module_event_flag && flag_interrupt_enable;
      wdt_cnt_q        <= wdt_cnt_d;
      internal_reset_q <= internal_reset_d;
    end
  end

  // ==========================================================
  // read port, data valid one cycle after the strobe and zero otherwise
  always @* begin
    reg_rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `ACC_REG_MODE:     reg_rdata_d = module_mode_control_q;
        `ACC_REG_CAP_LOW:  reg_rdata_d = module_low_byte_q;
        `ACC_REG_CAP_HIGH: reg_rdata_d = module_high_byte_q;
        `ACC_REG_TMR_LOW:  reg_rdata_d = timer_q[7:0];
        `ACC_REG_TMR_HIGH: reg_rdata_d = timer_q[15:8];
        `ACC_REG_CTRL:     reg_rdata_d = array_counter_control_q;
        `ACC_REG_IRQ_STAT: reg_rdata_d = irq_stat_q;
        `ACC_REG_IRQ_MASK: reg_rdata_d = irq_mask_q;
        default:           reg_rdata_d = 8'h00;
      endcase
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q <= 8'h00;
    end else if (ce) begin
      reg_rdata_q <= reg_rdata_d;
    end
  end
endmodule // acc_module
